// ### testbench/cmss_mode_select_bench.sv
// Bench for the mode select block: register access and fetch decode.
// Assumes the checker is compiled alongside.
`timescale 1ns/1ps
module cmss_mode_select_bench;
	reg clk,srst=1,mem_wr=0,mem_rd=0,fetch_valid=0;
	reg [11:0] mem_addr=12'hF84;
	reg [3:0] mem_wdata=4'h0;
	reg [2:0] fetch_op=3'h0;
	wire [3:0] mem_rdata;
	wire mem_hit,legacy_mode,extended_mode,dec_valid,op_unavailable,area_prohibited;
	wire [1:0] stack_bytes;
	wire [2:0] call_cycles;
	integer fails=0,n_checks=0,m,k,l;
	cmss_mode_select u_cmss_mode_select(.clk(clk),.srst(srst),.mem_wr(mem_wr),.mem_rd(mem_rd),.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),.mem_rdata(mem_rdata),.mem_hit(mem_hit),.fetch_valid(fetch_valid),.fetch_op(fetch_op),
		.legacy_mode(legacy_mode),.extended_mode(extended_mode),.dec_valid(dec_valid),.stack_bytes(stack_bytes),
		.call_cycles(call_cycles),.op_unavailable(op_unavailable),.area_prohibited(area_prohibited));
	initial
	begin
		clk=0;
		forever #2.5 clk=~clk;
	end
	// Compare and report
	task chk(input [39:0] n,input [3:0] g,e);
	begin
		n_checks=n_checks+1;
		if(g!==e)
		begin
			fails=fails+1;
			$display("CHECK FAILED %s exp %h got %h",n,e,g);
		end
	end
	endtask
	// One register access: raised at an edge, taken at the next, answer read at the falling edge
	task acc(input w,input [11:0] ad,input [3:0] d);
	begin
		@(posedge clk);
		mem_wr<=w;
		mem_rd<=!w;
		mem_addr<=ad;
		mem_wdata<=d;
		@(posedge clk);
		mem_wr<=0;
		mem_rd<=0;
		@(negedge clk);
	end
	endtask
	// One fetch of an instruction class, answer read at the falling edge
	task f(input [2:0] o);
	begin
		@(posedge clk);
		fetch_valid<=1;
		fetch_op<=o;
		@(posedge clk);
		fetch_valid<=0;
		@(negedge clk);
	end
	endtask
	task test_done;
	begin
		if(fails==0&&n_checks>0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat(12) @(posedge clk);
		srst<=0;
		@(negedge clk);
		chk("mode",legacy_mode,4'h1);
		chk("ext",extended_mode,4'h0);
		acc(0,12'hF84,4'h0);
		chk("rdat",mem_rdata,4'h8);
		chk("hit",mem_hit,4'h1);
		// Write, then fetch in the very next cycle: the fetch sees the new mode
		@(posedge clk);
		mem_wr<=1;
		mem_wdata<=4'h0;
		@(posedge clk);
		mem_wr<=0;
		fetch_valid<=1;
		fetch_op<=3'h1;
		@(posedge clk);
		fetch_valid<=0;
		@(negedge clk);
		chk("new",stack_bytes,4'h3);
		chk("ncyc",call_cycles,4'h4);
		for(m=0;m<3;m=m+1)
		begin
			l=(m==1);
			acc(1,12'hF84,l?4'h8:4'h0);
			chk("whit",mem_hit,4'h1);
			for(k=1;k<6;k=k+1)
			begin
				f(k[2:0]);
				chk("dec",dec_valid,4'h1);
				chk("push",stack_bytes,l?4'h2:4'h3);
				if(k<3) chk("cyc",call_cycles,k==1?(l?4'h3:4'h4):(l?4'h2:4'h3));
				chk("unav",op_unavailable,(k>3&&l)?4'h1:4'h0);
			end
			chk("mode",legacy_mode,l?4'h1:4'h0);
			chk("ext",extended_mode,l?4'h0:4'h1);
			chk("prob",area_prohibited,4'h0);
		end
		// Other addresses are ignored and leave the register alone
		acc(1,12'hF85,4'h8);
		chk("miss",mem_hit,4'h0);
		acc(0,12'hF85,4'h0);
		chk("hit",mem_hit,4'h0);
		chk("mdat",mem_rdata,4'h0);
		acc(0,12'hF84,4'h0);
		chk("rdat",mem_rdata,4'h0);
		// A prohibited setting is stored as written and flagged
		acc(1,12'hF84,4'h5);
		acc(0,12'hF84,4'h0);
		chk("pdat",mem_rdata,4'h5);
		chk("prob",area_prohibited,4'h1);
		// Reset in mid-run brings back legacy mode
		@(posedge clk);
		srst<=1;
		@(posedge clk);
		srst<=0;
		@(negedge clk);
		chk("mode",legacy_mode,4'h1);
		acc(0,12'hF84,4'h0);
		chk("rdat",mem_rdata,4'h8);
		chk("prob",area_prohibited,4'h0);
		test_done;
	end
	// Watchdog
	initial
	begin
		#5000;
		fails=fails+1;
		test_done;
	end
endmodule

// ### testbench/cmss_mode_select_checker.sv
// Checker for the mode select register and decode answers.
// Assumes it is bound onto the design's top module.
`timescale 1ns/1ps
module cmss_mode_select_checker
(
	input wire clk,
	input wire srst,
	input wire mem_wr,
	input wire mem_rd,
	input wire [11:0] mem_addr,
	input wire [3:0] mem_wdata,
	input wire [3:0] mem_rdata,
	input wire mem_hit,
	input wire fetch_valid,
	input wire [2:0] fetch_op,
	input wire legacy_mode,
	input wire extended_mode,
	input wire dec_valid,
	input wire [1:0] stack_bytes,
	input wire [2:0] call_cycles,
	input wire op_unavailable,
	input wire area_prohibited
);
	// Register address hit, written mode bit and written prohibited setting
	wire a=mem_addr==12'hF84;
	wire w3=mem_wdata[3];
	wire wprob=mem_wdata[2]|(mem_wdata[1:0]!=2'h0);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	AST_MODE: assert property(mem_wr&&a|=>##1 legacy_mode==$past(w3,2)&&extended_mode!=legacy_mode)else $error("mode");
	AST_PUSH: assert property(dec_valid|->stack_bytes==(legacy_mode?2'h2:2'h3))else $error("push");
	AST_UNAV: assert property(fetch_valid&&fetch_op[2:1]==2'h2|=>op_unavailable==legacy_mode)else $error("unav");
	AST_ACALL: assert property(fetch_valid&&fetch_op==3'h1|=>call_cycles==(legacy_mode?3'h3:3'h4))else $error("acall");
	AST_FCALL: assert property(fetch_valid&&fetch_op==3'h2|=>call_cycles==(legacy_mode?3'h2:3'h3))else $error("fcall");
	AST_RST: assert property($fell(srst)|->legacy_mode&&!extended_mode##1 legacy_mode&&!extended_mode)else $error("rst");
	AST_PROB: assert property(mem_wr&&a|=>##1 area_prohibited==$past(wprob,2))else $error("prob");
	AST_RD: assert property(mem_rd&&a&&!mem_wr|=>mem_hit&&mem_rdata[3]==legacy_mode)else $error("rd");
	AST_NEW: assert property(mem_wr&&a&&!w3##1 fetch_valid|=>stack_bytes==2'h3)else $error("new");
endmodule
bind cmss_mode_select cmss_mode_select_checker u_cmss_mode_select_checker
(
	.clk(clk),
	.srst(srst),
	.mem_wr(mem_wr),
	.mem_rd(mem_rd),
	.mem_addr(mem_addr),
	.mem_wdata(mem_wdata),
	.mem_rdata(mem_rdata),
	.mem_hit(mem_hit),
	.fetch_valid(fetch_valid),
	.fetch_op(fetch_op),
	.legacy_mode(legacy_mode),
	.extended_mode(extended_mode),
	.dec_valid(dec_valid),
	.stack_bytes(stack_bytes),
	.call_cycles(call_cycles),
	.op_unavailable(op_unavailable),
	.area_prohibited(area_prohibited)
);

// ### verilog/cmss_defs.vh
// Constants for the CPU mode and stack bank select block.
// Assumes a 4-bit data memory bus with a 12-bit address, one CPU clock per machine cycle.
// How it works
// - Mode bit 3 of the register: one is legacy mode, zero extended mode.
// - Calls push two stack bytes in legacy mode, three in extended mode; returns match.
// - Long-range branch and long-range call execute only in extended mode.
// - Absolute call 3 or 4 cycles; fast call 2 or 3 cycles, legacy or extended.
// - Any system reset sets the mode bit, so execution starts in legacy mode.
// - Register sits at data address F84H, written whole by a 4-bit instruction.
`ifndef CMSS_DEFS_VH
`define CMSS_DEFS_VH
`define CMSS_ADDR_W 12
`define CMSS_DATA_W 4
`define CMSS_SBMS_ADDR 12'hF84
`define CMSS_SBMS_RESET 4'h8
`define CMSS_MODE_BIT 3
`define CMSS_MBZ_BIT 2
`define CMSS_AREA_HI 1
`define CMSS_AREA_LO 0
`define CMSS_AREA_BANK0 2'h0
`define CMSS_PUSH_LEGACY 2'h2
`define CMSS_PUSH_EXT 2'h3
`define CMSS_ACALL_LEGACY 3'h3
`define CMSS_ACALL_EXT 3'h4
`define CMSS_FCALL_LEGACY 3'h2
`define CMSS_FCALL_EXT 3'h3
`define CMSS_OP_W 3
`define CMSS_OP_OTHER 3'h0
`define CMSS_OP_CALL 3'h1
`define CMSS_OP_FCALL 3'h2
`define CMSS_OP_RET 3'h3
`define CMSS_OP_LBRANCH 3'h4
`define CMSS_OP_LCALL 3'h5
`define CMSS_BYTES_W 2
`define CMSS_CYC_W 3
`define CMSS_RDATA_IDLE 4'h0
`define CMSS_FLAG_CLEAR 1'h0
`define CMSS_FLAG_SET 1'h1
`endif

// ### verilog/cmss_mode_select.v
// Mode select register and the mode-dependent decode answers for the CPU core.
// Assumes the core presents one decoded instruction class per fetch strobe.
// Assumes all inputs come from core logic on the same clock, so none is synchronised.
`timescale 1ns/1ps
`include "cmss_defs.vh"

// Chooses the legacy or the extended figure of one mode-dependent answer
module cmss_mode_pick
#(
	parameter W = 2
)
(
	input wire sel_legacy,
	input wire [W-1:0] val_legacy,
	input wire [W-1:0] val_extended,
	output wire [W-1:0] picked
);

	// Plain two-way choice, no state
	assign picked = sel_legacy ? val_legacy : val_extended;

endmodule

module cmss_mode_select
(
	input wire clk,
	input wire srst,
	input wire mem_wr,
	input wire mem_rd,
	input wire [`CMSS_ADDR_W-1:0] mem_addr,
	input wire [`CMSS_DATA_W-1:0] mem_wdata,
	output reg [`CMSS_DATA_W-1:0] mem_rdata,
	output reg mem_hit,
	input wire fetch_valid,
	input wire [`CMSS_OP_W-1:0] fetch_op,
	output reg legacy_mode,
	output reg extended_mode,
	output reg dec_valid,
	output reg [`CMSS_BYTES_W-1:0] stack_bytes,
	output reg [`CMSS_CYC_W-1:0] call_cycles,
	output reg op_unavailable,
	output reg area_prohibited
);

	// Stored register and its next value
	reg [`CMSS_DATA_W-1:0] sbms_reg;
	reg [`CMSS_DATA_W-1:0] sbms_next;

	// Address decode and the mode taken from the stored bit
	wire sel;
	wire sel_wr;
	wire sel_rd;
	wire mode_legacy;

	// Mode-dependent figures and next values of the output flops
	wire [`CMSS_BYTES_W-1:0] push_pick;
	wire [`CMSS_CYC_W-1:0] acall_pick;
	wire [`CMSS_CYC_W-1:0] fcall_pick;
	wire [`CMSS_DATA_W-1:0] rdata_next;
	wire hit_next;
	wire prohibited_next;
	reg [`CMSS_BYTES_W-1:0] bytes_next;
	reg [`CMSS_CYC_W-1:0] cycles_next;
	reg unavail_next;

	// One address compare serves both strobes
	assign sel = (mem_addr == `CMSS_SBMS_ADDR);
	assign sel_wr = mem_wr & sel;
	assign sel_rd = mem_rd & sel;

	// Mode decoded from the stored register only, so a write lands before later fetches
	assign mode_legacy = sbms_reg[`CMSS_MODE_BIT];

	// Whole-nibble write of the register
	always @*
	begin
		sbms_next = sbms_reg;
		if (sel_wr)
		begin
			sbms_next = mem_wdata;
		end
	end

	// Register, reset to legacy mode
	always @(posedge clk)
	begin
		if (srst)
		begin
			sbms_reg <= `CMSS_SBMS_RESET;
		end
		else
		begin
			sbms_reg <= sbms_next;
		end
	end

	// Stack bytes pushed by a call, and unwound by a return, in the current mode
	cmss_mode_pick
	#(
		.W(`CMSS_BYTES_W)
	)
	u_push_pick
	(
		.sel_legacy(mode_legacy),
		.val_legacy(`CMSS_PUSH_LEGACY),
		.val_extended(`CMSS_PUSH_EXT),
		.picked(push_pick)
	);

	// Machine cycles of an absolute call in the current mode
	cmss_mode_pick
	#(
		.W(`CMSS_CYC_W)
	)
	u_acall_pick
	(
		.sel_legacy(mode_legacy),
		.val_legacy(`CMSS_ACALL_LEGACY),
		.val_extended(`CMSS_ACALL_EXT),
		.picked(acall_pick)
	);

	// Machine cycles of a fast call in the current mode
	cmss_mode_pick
	#(
		.W(`CMSS_CYC_W)
	)
	u_fcall_pick
	(
		.sel_legacy(mode_legacy),
		.val_legacy(`CMSS_FCALL_LEGACY),
		.val_extended(`CMSS_FCALL_EXT),
		.picked(fcall_pick)
	);

	// Per-instruction answers from the current mode
	always @*
	begin
		bytes_next = push_pick;
		cycles_next = `CMSS_ACALL_LEGACY;
		unavail_next = `CMSS_FLAG_CLEAR;
		case (fetch_op)
			`CMSS_OP_CALL:
			begin
				cycles_next = acall_pick;
			end
			`CMSS_OP_FCALL:
			begin
				cycles_next = fcall_pick;
			end
			`CMSS_OP_RET:
			begin
				// Only the byte count matters for a return
				cycles_next = `CMSS_ACALL_LEGACY;
			end
			`CMSS_OP_LBRANCH, `CMSS_OP_LCALL:
			begin
				cycles_next = `CMSS_ACALL_EXT;
				unavail_next = mode_legacy;
			end
			default:
			begin
				cycles_next = `CMSS_ACALL_LEGACY;
			end
		endcase
	end

	// Read answers; other addresses read as idle
	assign rdata_next = sel_rd ? sbms_reg : `CMSS_RDATA_IDLE;
	assign hit_next = sel_rd | sel_wr;

	// Flags a setting software must not use
	assign prohibited_next = sbms_reg[`CMSS_MBZ_BIT] |
		(sbms_reg[`CMSS_AREA_HI:`CMSS_AREA_LO] != `CMSS_AREA_BANK0);

	// Read data and hit flops
	always @(posedge clk)
	begin
		if (srst)
		begin
			mem_rdata <= `CMSS_RDATA_IDLE;
			mem_hit <= `CMSS_FLAG_CLEAR;
		end
		else
		begin
			mem_rdata <= rdata_next;
			mem_hit <= hit_next;
		end
	end

	// Mode outputs, one cycle behind the stored bit
	always @(posedge clk)
	begin
		if (srst)
		begin
			legacy_mode <= `CMSS_FLAG_SET;
			extended_mode <= `CMSS_FLAG_CLEAR;
		end
		else
		begin
			legacy_mode <= mode_legacy;
			extended_mode <= ~mode_legacy;
		end
	end

	// Decode answer flops, one cycle after the fetch
	always @(posedge clk)
	begin
		if (srst)
		begin
			dec_valid <= `CMSS_FLAG_CLEAR;
			stack_bytes <= `CMSS_PUSH_LEGACY;
			call_cycles <= `CMSS_ACALL_LEGACY;
			op_unavailable <= `CMSS_FLAG_CLEAR;
		end
		else
		begin
			dec_valid <= fetch_valid;
			stack_bytes <= bytes_next;
			call_cycles <= cycles_next;
			op_unavailable <= fetch_valid & unavail_next;
		end
	end

	// Status flop for prohibited settings
	always @(posedge clk)
	begin
		if (srst)
		begin
			area_prohibited <= `CMSS_FLAG_CLEAR;
		end
		else
		begin
			area_prohibited <= prohibited_next;
		end
	end

endmodule
